/* File: rgb_parallel_serial_link_tb_top.sv */
`timescale 1ns/1ps
`include "rgbl_map.vh"
module rgb_parallel_serial_link_tb_top;
    localparam LOCK = 20;
    reg         clk, rst, sleep_n, run, fast, chk_en, fclk_d;
    reg [3:0]   idle_cnt;
    wire        pclk, fclk, fclk_oe, locked, ovf, pclk_out;
    wire [20:0] word, word_out;
    wire [2:0]  lane_out, lane_oe;
    integer     bad_count, total_checks, slot;
    reg [20:0]  txq[$];
    reg [20:0]  rxq[$];
    reg [20:0]  cur_tx, cur_rx, held;

    rgbl_host_model u_host (.run(run), .fast(fast), .pclk(pclk), .word(word));
    rgbl_link #(.LOCK_WAIT_CYCLES(LOCK)) u_dut (.CORE_CLK(clk), .RESET(rst),
        .SLEEP_REQUEST_N(sleep_n), .LINK_LOCKED(locked), .PIXEL_CLOCK_IN(pclk),
        .PARALLEL_WORD_IN(word), .TX_OVERFLOW(ovf), .SERIAL_LANE_OUT(lane_out),
        .SERIAL_LANE_OE(lane_oe), .FORWARDED_LANE_CLOCK(fclk), .FORWARDED_LANE_CLOCK_OE(fclk_oe),
        .SERIAL_LANE_IN((lane_out & lane_oe) | ({3{idle_cnt[0]}} & ~lane_oe)),
        .RECEIVED_LANE_CLOCK((fclk & fclk_oe) | (idle_cnt[3] & ~fclk_oe)),
        .PARALLEL_WORD_OUT(word_out),
        .PIXEL_CLOCK_OUT(pclk_out));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task check(input [20:0] got, input [20:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task tally_and_finish;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Host words at the strobe, lanes slot by slot, panel words at its strobe
    always @(negedge pclk)
        if (chk_en)
            txq.push_back(word);
    always @(posedge clk)
    begin
        // Released lanes keep wiggling, so a receiver that fails to freeze decodes junk
        idle_cnt <= idle_cnt + 4'h1;
        if (chk_en && fclk && !fclk_d)
        begin
            cur_tx = txq.size() ? txq.pop_front() : 21'h1fffff;
            rxq.push_back(cur_tx);
            slot = 0;
        end
        if (chk_en && slot < 7)
        begin
            check({18'h0, lane_out}, {18'h0, cur_tx[14+slot], cur_tx[7+slot], cur_tx[slot]});
            slot = slot + 1;
        end
        fclk_d = fclk;
    end
    always @(negedge pclk_out)
        if (chk_en)
        begin
            cur_rx = rxq.size() ? rxq.pop_front() : ~word_out;
            check(word_out, cur_rx);
        end

    task wait_lock;
        integer n;
        n = 0;
        while (!locked && n < 200)
        begin
            @(posedge clk);
            n = n + 1;
        end
        check({20'h0, n >= LOCK}, 21'h1);
        check({20'h0, locked}, 21'h1);
        if (locked !== 1'b1)
            tally_and_finish;
    endtask

    task t_stream(input integer n);
        @(posedge clk);
        run <= 1'b1;
        repeat (n * 8) @(posedge clk);
        run <= 1'b0;
        repeat (60) @(posedge clk);
        check(21'(txq.size() + rxq.size()), 21'h0);
    endtask

    task t_sleep;
        held = word_out;
        sleep_n <= 1'b0;
        repeat (40) @(posedge clk);
        check(word_out, held);
        check({17'h0, fclk_oe, lane_oe}, 21'h0);
        sleep_n <= 1'b1;
        wait_lock;
        t_stream(6);
    endtask

    task t_overflow;
        chk_en <= 1'b0;
        fast <= 1'b1;
        run <= 1'b1;
        repeat (120) @(posedge clk);
        run <= 1'b0;
        fast <= 1'b0;
        repeat (20) @(posedge clk);
        check({20'h0, ovf}, 21'h1);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({16'h0, ovf, fclk_oe, lane_oe}, 21'h0);
        check(word_out, 21'h0);
    endtask

    initial
    begin
        rst = 1'b1;
        sleep_n = 1'b1;
        run = 1'b0;
        fast = 1'b0;
        chk_en = 1'b0;
        idle_cnt = 4'h0;
        fclk_d = 1'b0;
        slot = 7;
        bad_count = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wait_lock;
        chk_en <= 1'b1;
        t_stream(12);
        t_sleep;
        t_overflow;
        tally_and_finish;
    end

    initial
    begin
        #400000;
        bad_count = bad_count + 1;
        tally_and_finish;
    end
endmodule

/* File: rgbl_fifo.v */
`timescale 1ns/1ps
module rgbl_fifo #(
    parameter WIDTH = 21,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    input  wire             flush,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
        if (rst | flush)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            if (push & ~pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop & ~push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

/* File: rgbl_host_model.sv */
`timescale 1ns/1ps
module rgbl_host_model (
    // Control from bench
    input wire         run,
    input wire         fast,
    // Host pins
    output reg         pclk,
    output reg  [20:0] word
);
    integer    idx;
    integer    half;
    reg [17:0] colour;
    initial
    begin
        pclk = 1'b1;
        word = 21'h0;
        idx  = 0;
        #7;
        forever
        begin
            half = fast ? 40 : 80;
            if (run)
            begin
                colour = idx * 18'h2a5b3 ^ 18'h15c3a;
                word = {1'b1, idx[4:0] == 5'h0, idx[1:0] == 2'h0, colour};
                #half pclk = 1'b0;
                #half pclk = 1'b1;
                idx = idx + 1;
            end
            else
            begin
                // Released lines must not look like held data
                #half word = ~word;
            end
        end
    end
endmodule

/* File: rgbl_link.v */
`timescale 1ns/1ps
`include "rgbl_map.vh"
module rgbl_link #(
    parameter LOCK_WAIT_CYCLES = `RGBL_LOCK_MS * `RGBL_CORE_MHZ * 1000
) (
    // Clock and reset
    input  wire                        CORE_CLK,
    input  wire                        RESET,
    // Power control
    input  wire                        SLEEP_REQUEST_N,
    output reg                         LINK_LOCKED,
    // Host parallel side
    input  wire                        PIXEL_CLOCK_IN,
    input  wire [`RGBL_WORD_W-1:0]     PARALLEL_WORD_IN,
    output reg                         TX_OVERFLOW,
    // Transmit lanes
    output reg  [`RGBL_LANES-1:0]      SERIAL_LANE_OUT,
    output reg  [`RGBL_LANES-1:0]      SERIAL_LANE_OE,
    output reg                         FORWARDED_LANE_CLOCK,
    output reg                         FORWARDED_LANE_CLOCK_OE,
    // Receive lanes
    input  wire [`RGBL_LANES-1:0]      SERIAL_LANE_IN,
    input  wire                        RECEIVED_LANE_CLOCK,
    // Panel parallel side
    output reg  [`RGBL_WORD_W-1:0]     PARALLEL_WORD_OUT,
    output reg                         PIXEL_CLOCK_OUT
);
    localparam [1:0] TX_IDLE  = 2'b01;
    localparam [1:0] TX_SHIFT = 2'b10;
    localparam [`RGBL_LOCK_W-1:0] LOCK_LOAD = LOCK_WAIT_CYCLES[`RGBL_LOCK_W-1:0];

    // Two-stage synchronisers on every pin from outside the core domain
    reg [1:0]                 sleep_s_q;
    reg [2:0]                 pclk_s_q;
    reg [`RGBL_WORD_W-1:0]    win_s1_q;
    reg [`RGBL_WORD_W-1:0]    win_s2_q;
    reg [2:0]                 lclk_s_q;
    reg [`RGBL_LANES-1:0]     lin_s1_q;
    reg [`RGBL_LANES-1:0]     lin_s2_q;

    always @(posedge CORE_CLK)
    begin
        sleep_s_q <= {sleep_s_q[0], SLEEP_REQUEST_N};
        pclk_s_q  <= {pclk_s_q[1:0], PIXEL_CLOCK_IN};
        win_s1_q  <= PARALLEL_WORD_IN;
        win_s2_q  <= win_s1_q;
        lclk_s_q  <= {lclk_s_q[1:0], RECEIVED_LANE_CLOCK};
        lin_s1_q  <= SERIAL_LANE_IN;
        lin_s2_q  <= lin_s1_q;
    end

    wire awake   = sleep_s_q[1];
    wire pfall   = pclk_s_q[2] & ~pclk_s_q[1];
    wire lrise   = ~lclk_s_q[2] & lclk_s_q[1];

    // Lock wait after reset or wake; link data is ignored until it ends
    reg [`RGBL_LOCK_W-1:0] lock_cnt_q;
    wire locked = (lock_cnt_q == {`RGBL_LOCK_W{1'b0}});

    always @(posedge CORE_CLK)
    begin
        if (RESET | ~awake)
        begin
            lock_cnt_q  <= LOCK_LOAD;
            LINK_LOCKED <= 1'b0;
        end
        else
        begin
            if (!locked)
            begin
                lock_cnt_q <= lock_cnt_q - 1'b1;
            end
            LINK_LOCKED <= locked;
        end
    end

    // Capture path into the word buffer; a full buffer drops the word
    wire                    fifo_in_ready;
    wire                    fifo_out_valid;
    wire [`RGBL_WORD_W-1:0] fifo_out_data;
    wire                    cap_valid = pfall & awake & locked;
    reg                     pop;

    rgbl_fifo #(
        .WIDTH (`RGBL_WORD_W),
        .DEPTH (`RGBL_FIFO_DEPTH),
        .AW    (`RGBL_FIFO_AW)
    ) u_fifo (
        .clk       (CORE_CLK),
        .rst       (RESET),
        .flush     (~awake),
        .in_valid  (cap_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (win_s2_q),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data)
    );

    always @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            TX_OVERFLOW <= 1'b0;
        end
        else if (cap_valid & ~fifo_in_ready)
        begin
            TX_OVERFLOW <= 1'b1;
        end
    end

    // Serializer: one core cycle per slot, so a word takes seven cycles.
    // Slower than real line rate, but keeps one clock domain.
    reg [1:0]                 tx_state_q;
    reg [2:0]                 tx_slot_q;
    reg [`RGBL_WORD_W-1:0]    tx_word_q;
    wire last_slot = (tx_slot_q == `RGBL_SLOT_LAST);

    always @*
    begin
        pop = 1'b0;
        case (tx_state_q)
            TX_IDLE:  pop = fifo_out_valid & awake & locked;
            TX_SHIFT: pop = last_slot & fifo_out_valid & awake & locked;
            default:  pop = 1'b0;
        endcase
    end

    // Lane l carries word bits l*7 .. l*7+6, slot s being bit l*7+s
    integer l;
    always @(posedge CORE_CLK)
    begin
        if (RESET | ~awake)
        begin
            tx_state_q              <= TX_IDLE;
            tx_slot_q               <= 3'h0;
            tx_word_q               <= {`RGBL_WORD_W{1'b0}};
            SERIAL_LANE_OUT         <= {`RGBL_LANES{1'b0}};
            SERIAL_LANE_OE          <= {`RGBL_LANES{1'b0}};
            FORWARDED_LANE_CLOCK    <= 1'b0;
            FORWARDED_LANE_CLOCK_OE <= 1'b0;
        end
        else
        begin
            SERIAL_LANE_OE          <= {`RGBL_LANES{1'b1}};
            FORWARDED_LANE_CLOCK_OE <= 1'b1;
            if (pop)
            begin
                tx_state_q           <= TX_SHIFT;
                tx_slot_q            <= 3'h0;
                tx_word_q            <= fifo_out_data;
                FORWARDED_LANE_CLOCK <= 1'b1;
                for (l = 0; l < `RGBL_LANES; l = l + 1)
                begin
                    SERIAL_LANE_OUT[l] <= fifo_out_data[l*`RGBL_SLOTS];
                end
            end
            else if (tx_state_q == TX_SHIFT && !last_slot)
            begin
                tx_slot_q            <= tx_slot_q + 1'b1;
                FORWARDED_LANE_CLOCK <= (tx_slot_q + 1'b1) < `RGBL_CLK_HI_END;
                for (l = 0; l < `RGBL_LANES; l = l + 1)
                begin
                    SERIAL_LANE_OUT[l] <= tx_word_q[l*`RGBL_SLOTS + tx_slot_q + 1];
                end
            end
            else
            begin
                tx_state_q           <= TX_IDLE;
                FORWARDED_LANE_CLOCK <= 1'b0;
            end
        end
    end

    // Deserializer: slot 0 sits with the lane clock rise, slots follow each cycle
    reg                       rx_busy_q;
    reg [2:0]                 rx_slot_q;
    reg [`RGBL_WORD_W-1:0]    rx_word_q;
    reg [2:0]                 rx_hi_q;
    reg [`RGBL_WORD_W-1:0]    rx_next;
    integer                   m;
    wire rx_run = awake & locked;

    always @*
    begin
        rx_next = rx_word_q;
        for (m = 0; m < `RGBL_LANES; m = m + 1)
        begin
            rx_next[m*`RGBL_SLOTS + (lrise ? 0 : rx_slot_q)] = lin_s2_q[m];
        end
    end

    always @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            rx_busy_q         <= 1'b0;
            rx_slot_q         <= 3'h0;
            rx_word_q         <= {`RGBL_WORD_W{1'b0}};
            rx_hi_q           <= 3'h0;
            PARALLEL_WORD_OUT <= {`RGBL_WORD_W{1'b0}};
            PIXEL_CLOCK_OUT   <= 1'b0;
        end
        else if (!rx_run)
        begin
            rx_busy_q <= 1'b0;  // outputs keep last values
        end
        else
        begin
            if (lrise)
            begin
                rx_busy_q <= 1'b1;
                rx_slot_q <= 3'h1;
                rx_word_q <= rx_next;
            end
            else if (rx_busy_q)
            begin
                rx_word_q <= rx_next;
                rx_slot_q <= rx_slot_q + 1'b1;
                if (rx_slot_q == `RGBL_SLOT_LAST)
                begin
                    rx_busy_q         <= 1'b0;
                    PARALLEL_WORD_OUT <= rx_next;
                    PIXEL_CLOCK_OUT   <= 1'b1;
                    rx_hi_q           <= `RGBL_PCLK_HI;
                end
            end
            // Falling edge comes after the word has settled
            if (rx_hi_q != 3'h0 && !(rx_busy_q && rx_slot_q == `RGBL_SLOT_LAST && !lrise))
            begin
                rx_hi_q <= rx_hi_q - 1'b1;
                if (rx_hi_q == 3'h1)
                begin
                    PIXEL_CLOCK_OUT <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: rgbl_link_asserts.sv */
`timescale 1ns/1ps
`include "rgbl_map.vh"
module rgbl_link_asserts #(
    parameter LOCK_WAIT_CYCLES = 20
) (
    // Clock, reset, power and overflow flag
    input wire                      CORE_CLK,
    input wire                      RESET,
    input wire                      SLEEP_REQUEST_N,
    input wire                      LINK_LOCKED,
    input wire                      TX_OVERFLOW,
    // Transmit lanes
    input wire [`RGBL_LANES-1:0]    SERIAL_LANE_OUT,
    input wire [`RGBL_LANES-1:0]    SERIAL_LANE_OE,
    input wire                      FORWARDED_LANE_CLOCK,
    input wire                      FORWARDED_LANE_CLOCK_OE,
    // Panel side
    input wire [`RGBL_WORD_W-1:0]   PARALLEL_WORD_OUT,
    input wire                      PIXEL_CLOCK_OUT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    // Counts from the pin, so it runs ahead of the synced view: safe bound
    integer awake_q;
    always @(posedge CORE_CLK)
        if (RESET || !SLEEP_REQUEST_N)
            awake_q <= 0;
        else if (awake_q < LOCK_WAIT_CYCLES)
            awake_q <= awake_q + 1;

    // Five samples cover the two-stage pin sync and the output register
    sequence s_asleep;
        !SLEEP_REQUEST_N [*5];
    endsequence
    sequence s_fwd_frame;
        FORWARDED_LANE_CLOCK [*4] ##1 !FORWARDED_LANE_CLOCK [*3];
    endsequence

    a_fwd_clock_duty: assert property ($rose(FORWARDED_LANE_CLOCK) |-> s_fwd_frame)
        else $error("forwarded clock not high 4 then low 3");
    a_sleep_float: assert property (s_asleep |-> SERIAL_LANE_OE == 3'h0 && !FORWARDED_LANE_CLOCK_OE)
        else $error("lanes still enabled in power-down");
    a_idle_lanes_quiet: assert property (!FORWARDED_LANE_CLOCK_OE |-> SERIAL_LANE_OUT == 3'h0 && !FORWARDED_LANE_CLOCK)
        else $error("lanes switching while disabled");
    a_sleep_hold_word: assert property (s_asleep |-> $stable(PARALLEL_WORD_OUT) && !$rose(PIXEL_CLOCK_OUT))
        else $error("receiver output moved in power-down");
    a_pclk_out_width: assert property ($rose(PIXEL_CLOCK_OUT) |-> PIXEL_CLOCK_OUT [*4] ##1 !PIXEL_CLOCK_OUT)
        else $error("recovered clock high time wrong");
    a_word_on_rise: assert property ($changed(PARALLEL_WORD_OUT) |-> $rose(PIXEL_CLOCK_OUT))
        else $error("word changed away from recovered clock rise");
    a_lock_wait_done: assert property ($rose(LINK_LOCKED) |-> awake_q >= LOCK_WAIT_CYCLES)
        else $error("lock reported before wait elapsed");
    a_lock_drop_sleep: assert property (s_asleep |-> !LINK_LOCKED)
        else $error("lock held in power-down");
    a_overflow_sticky: assert property (TX_OVERFLOW |=> TX_OVERFLOW)
        else $error("overflow flag cleared without reset");
endmodule

bind rgbl_link rgbl_link_asserts #(.LOCK_WAIT_CYCLES(LOCK_WAIT_CYCLES)) u_chk (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .SLEEP_REQUEST_N(SLEEP_REQUEST_N),
    .LINK_LOCKED(LINK_LOCKED), .TX_OVERFLOW(TX_OVERFLOW), .SERIAL_LANE_OUT(SERIAL_LANE_OUT),
    .SERIAL_LANE_OE(SERIAL_LANE_OE), .FORWARDED_LANE_CLOCK(FORWARDED_LANE_CLOCK),
    .FORWARDED_LANE_CLOCK_OE(FORWARDED_LANE_CLOCK_OE),
    .PARALLEL_WORD_OUT(PARALLEL_WORD_OUT), .PIXEL_CLOCK_OUT(PIXEL_CLOCK_OUT));

/* File: rgbl_map.vh */
`ifndef RGBL_MAP_VH
`define RGBL_MAP_VH

`define RGBL_WORD_W      21
`define RGBL_LANES       3
`define RGBL_SLOTS       7
`define RGBL_SLOT_LAST   3'h6
`define RGBL_CLK_HI_END  3'h4
`define RGBL_RED_LSB     0
`define RGBL_GREEN_LSB   6
`define RGBL_BLUE_LSB    12
`define RGBL_LINE_SYNC   18
`define RGBL_FRAME_SYNC  19
`define RGBL_PIX_VALID   20
`define RGBL_FIFO_DEPTH  8
`define RGBL_FIFO_AW     3
`define RGBL_CORE_MHZ    50
`define RGBL_LOCK_MS     10
`define RGBL_LOCK_W      20
`define RGBL_PCLK_HI     3'h4

`endif
